// File: design/acgr_regs.vh
// acgr_regs.vh: addresses, field positions, reset values and codes
// for the converter gain and configuration register block.
// assumes: included by bare name from every design file.
`ifndef ACGR_REGS_VH
`define ACGR_REGS_VH
// ---------------------------------------------------------------
// special-function addresses
// ---------------------------------------------------------------
`define ACGR_SFR_INPUT_SELECT  8'hbb
`define ACGR_SFR_CONFIG        8'hbc
`define ACGR_SFR_RESULT_HIGH   8'hbe
`define ACGR_SFR_RESULT_LOW    8'hbd
// ---------------------------------------------------------------
// indirect gain addresses
// ---------------------------------------------------------------
`define ACGR_GAIN_ADDR_HIGH    8'h04
`define ACGR_GAIN_ADDR_LOW     8'h07
`define ACGR_GAIN_ADDR_EXTRA   8'h08
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ACGR_RST_GAIN_HIGH     8'hfc
`define ACGR_RST_GAIN_LOW      8'h00
`define ACGR_RST_GAIN_EXTRA    8'h01
`define ACGR_RST_INPUT_SELECT  8'h1f
`define ACGR_RST_CONFIG        8'hf8
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ACGR_CFG_DIV_MSB       7
`define ACGR_CFG_DIV_LSB       3
`define ACGR_CFG_RPT_MSB       2
`define ACGR_CFG_RPT_LSB       1
`define ACGR_CFG_GAIN_WE       0
`define ACGR_MUX_MSB           4
`define ACGR_GAIN_LOW_MSB      7
`define ACGR_GAIN_LOW_LSB      4
`define ACGR_GAIN_EXTRA_BIT    0
// ---------------------------------------------------------------
// input routing codes
// ---------------------------------------------------------------
`define ACGR_MUX_TEMP          5'h18
`define ACGR_MUX_SUPPLY        5'h19
`define ACGR_ROUTE_PIN         2'h0
`define ACGR_ROUTE_TEMP        2'h1
`define ACGR_ROUTE_SUPPLY      2'h2
`define ACGR_ROUTE_GROUND      2'h3
// ---------------------------------------------------------------
// gain arithmetic
// ---------------------------------------------------------------
`define ACGR_GAIN_SHIFT        12
`define ACGR_EXTRA_SHIFT       6
`endif

// File: design/acgr_clkdiv.v
// acgr_clkdiv.v: conversion clock enable, source divided by divider+1.
// assumes: src_tick marks each edge of the selected source clock.
`include "acgr_regs.vh"
module acgr_clkdiv #(
	parameter W = 5
) (
	input  wire         clock,
	input  wire         rst_n,
	input  wire         src_tick,
	input  wire [W-1:0] divider,
	output reg          sar_tick
);
	reg [W-1:0] count_q;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_q  <= {W{1'b0}};
			sar_tick <= 1'b0;
		end else begin
			sar_tick <= 1'b0;
			if (src_tick) begin
				if (count_q >= divider) begin // [RULE10]
					count_q  <= {W{1'b0}};
					sar_tick <= 1'b1;
				end else begin
					count_q <= count_q + {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // acgr_clkdiv

// File: design/acgr_accum.v
// acgr_accum.v: sums repeated conversion results into one word.
// assumes: sample_valid pulses once per finished single conversion.
`include "acgr_regs.vh"
module acgr_accum #(
	parameter RW = 12,
	parameter AW = 16
) (
	input  wire          clock,
	input  wire          rst_n,
	input  wire          clear,
	input  wire [1:0]    repeat_count,
	input  wire          sample_valid,
	input  wire [RW-1:0] sample,
	output reg  [AW-1:0] sum_out,
	output reg           sum_valid
);
	reg [AW-1:0] acc_q;
	reg [4:0]    n_q;
	reg [4:0]    target;
	always @* begin
		case (repeat_count) // [RULE12]
		2'b00:   target = 5'h01;
		2'b01:   target = 5'h04;
		2'b10:   target = 5'h08;
		default: target = 5'h10;
		endcase
	end
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			acc_q     <= {AW{1'b0}};
			n_q       <= 5'h00;
			sum_out   <= {AW{1'b0}};
			sum_valid <= 1'b0;
		end else begin
			sum_valid <= 1'b0;
			if (clear) begin
				acc_q <= {AW{1'b0}};
				n_q   <= 5'h00;
			end else if (sample_valid) begin
				if (n_q + 5'h01 >= target) begin
					// widened sum of all results [RULE13]
					sum_out   <= acc_q + {{(AW-RW){1'b0}}, sample};
					sum_valid <= 1'b1; // [RULE12]
					acc_q     <= {AW{1'b0}};
					n_q       <= 5'h00;
				end else begin
					acc_q <= acc_q + {{(AW-RW){1'b0}}, sample};
					n_q   <= n_q + 5'h01;
				end
			end
		end
	end
endmodule // acgr_accum

// File: design/acgr_top.v
// acgr_top.v: gain, input select and configuration registers of the
// converter, with conversion clock divider and result accumulation.
// assumes: single-cycle sfr write/read strobes, synchronous inputs;
// the analog core reports raw samples and takes the gain settings.
//
// How it works
// RULE1 - gain high register at indirect 0x04 holds gain bits 11 to 4.
// RULE2 - gain low at 0x07 holds gain bits 3..0 in 7..4; low nibble zero.
// RULE3 - extra gain register at 0x08, bit 0 flag, resets to one.
// RULE4 - effective gain is word over 4096, plus 1/64 when flag set.
// RULE5 - with write enable, result high selects address, result low loads.
// RULE6 - software should not convert while gain write enable is set.
// RULE7 - select codes route pins, temperature, supply, else ground.
// RULE8 - input select at 0xbb, top three bits unused, reset 0x1f.
// RULE9 - config at 0xbc: divider, repeat count, write enable; reset 0xf8.
// RULE10 - conversion clock is source divided by divider plus one.
// RULE11 - divider source is system clock, or burst oscillator in burst.
// RULE12 - repeat count gives 1, 4, 8 or 16 summed conversions.
// RULE13 - repeated results appear as their widened sum.
`include "acgr_regs.vh"
module acgr_top #(
	parameter RW = 12,
	parameter AW = 16
) (
	input  wire          clock,
	input  wire          rst_n,
	input  wire [7:0]    sfr_addr,
	input  wire          sfr_wr,
	input  wire [7:0]    sfr_wdata,
	input  wire          sfr_rd,
	output reg  [7:0]    sfr_rdata,
	input  wire          burst_enable,
	input  wire          burst_osc_tick,
	input  wire          conv_clear,
	input  wire          sample_valid,
	input  wire [RW-1:0] sample,
	output wire          sar_tick,
	output wire [11:0]   gain_word,
	output wire          extra_gain_flag,
	output wire [17:0]   gain_scaled,
	output wire [4:0]    input_select_field,
	output reg  [1:0]    input_route,
	output reg  [3:0]    input_pin,
	output wire [AW-1:0] result,
	output wire          result_valid,
	output wire          gain_write_enable
);
	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	reg [7:0]    gain_word_high_q;
	reg [3:0]    gain_word_low_q;
	reg          gain_extra_q;
	reg [4:0]    input_select_q;
	reg [7:0]    converter_config_q;
	reg [7:0]    gain_addr_q;
	reg [AW-1:0] result_q;
	reg          result_valid_q;
	wire [AW-1:0] sum_out;
	wire          sum_valid;
	wire          wr_cfg;
	wire          wr_mux;
	wire          wr_hi;
	wire          wr_lo;
	localparam [7:0] LOW_RST   = `ACGR_RST_GAIN_LOW;
	localparam [7:0] EXTRA_RST = `ACGR_RST_GAIN_EXTRA;
	localparam [7:0] SEL_RST   = `ACGR_RST_INPUT_SELECT;

	assign wr_cfg = sfr_wr && (sfr_addr == `ACGR_SFR_CONFIG);
	assign wr_mux = sfr_wr && (sfr_addr == `ACGR_SFR_INPUT_SELECT);
	assign wr_hi  = sfr_wr && (sfr_addr == `ACGR_SFR_RESULT_HIGH);
	assign wr_lo  = sfr_wr && (sfr_addr == `ACGR_SFR_RESULT_LOW);
	assign gain_write_enable = converter_config_q[`ACGR_CFG_GAIN_WE];

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gain_word_high_q   <= `ACGR_RST_GAIN_HIGH;
			gain_word_low_q    <=
				LOW_RST[`ACGR_GAIN_LOW_MSB:`ACGR_GAIN_LOW_LSB];
			gain_extra_q       <= EXTRA_RST[`ACGR_GAIN_EXTRA_BIT]; // [RULE3]
			input_select_q     <= SEL_RST[`ACGR_MUX_MSB:0]; // [RULE8]
			converter_config_q <= `ACGR_RST_CONFIG; // [RULE9]
			gain_addr_q        <= 8'h00;
		end else begin
			if (wr_cfg) begin
				converter_config_q <= sfr_wdata; // [RULE9]
			end
			if (wr_mux) begin
				input_select_q <= sfr_wdata[`ACGR_MUX_MSB:0]; // [RULE8]
			end
			if (gain_write_enable && wr_hi) begin
				gain_addr_q <= sfr_wdata; // [RULE5]
			end
			if (gain_write_enable && wr_lo) begin
				case (gain_addr_q) // [RULE5]
				`ACGR_GAIN_ADDR_HIGH: begin
					gain_word_high_q <= sfr_wdata; // [RULE1]
				end
				`ACGR_GAIN_ADDR_LOW: begin
					gain_word_low_q <=
						sfr_wdata[`ACGR_GAIN_LOW_MSB:`ACGR_GAIN_LOW_LSB]; // [RULE2]
				end
				`ACGR_GAIN_ADDR_EXTRA: begin
					gain_extra_q <= sfr_wdata[`ACGR_GAIN_EXTRA_BIT]; // [RULE3]
				end
				default: begin
				end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// gain outputs
	// ---------------------------------------------------------------
	assign gain_word       = {gain_word_high_q, gain_word_low_q}; // [RULE1]
	assign extra_gain_flag = gain_extra_q;
	// gain in units of 1/4096: word plus 64 when flag set [RULE4]
	assign gain_scaled = {6'h00, gain_word} +
		{11'h000, gain_extra_q, 6'h00};

	// ---------------------------------------------------------------
	// input routing
	// ---------------------------------------------------------------
	assign input_select_field = input_select_q;
	always @* begin
		input_pin   = input_select_q[3:0];
		input_route = `ACGR_ROUTE_GROUND;
		if (!input_select_q[4]) begin
			input_route = `ACGR_ROUTE_PIN; // [RULE7]
		end else if (input_select_q == `ACGR_MUX_TEMP) begin
			input_route = `ACGR_ROUTE_TEMP; // [RULE7]
		end else if (input_select_q == `ACGR_MUX_SUPPLY) begin
			input_route = `ACGR_ROUTE_SUPPLY; // [RULE7]
		end
	end

	// ---------------------------------------------------------------
	// conversion clock and accumulation
	// ---------------------------------------------------------------
	wire src_tick;
	assign src_tick = burst_enable ? burst_osc_tick : 1'b1; // [RULE11]

	acgr_clkdiv #(
		.W (5)
	) u_div (
		.clock    (clock),
		.rst_n    (rst_n),
		.src_tick (src_tick),
		.divider  (converter_config_q[`ACGR_CFG_DIV_MSB:`ACGR_CFG_DIV_LSB]),
		.sar_tick (sar_tick)
	);

	acgr_accum #(
		.RW (RW),
		.AW (AW)
	) u_acc (
		.clock        (clock),
		.rst_n        (rst_n),
		.clear        (conv_clear),
		.repeat_count (converter_config_q[`ACGR_CFG_RPT_MSB:`ACGR_CFG_RPT_LSB]),
		.sample_valid (sample_valid),
		.sample       (sample),
		.sum_out      (sum_out),
		.sum_valid    (sum_valid)
	);

	// valid pulse marks the cycle the new result stands
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			result_q       <= {AW{1'b0}};
			result_valid_q <= 1'b0;
		end else begin
			result_valid_q <= sum_valid; // [RULE12]
			if (sum_valid) begin
				result_q <= sum_out; // [RULE13]
			end
		end
	end
	assign result       = result_q;
	assign result_valid = result_valid_q;

	// ---------------------------------------------------------------
	// read path; gain registers never read back
	// ---------------------------------------------------------------
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			case (sfr_addr)
			`ACGR_SFR_INPUT_SELECT: sfr_rdata <= {3'b000, input_select_q};
			`ACGR_SFR_CONFIG:       sfr_rdata <= converter_config_q;
			`ACGR_SFR_RESULT_HIGH:  sfr_rdata <= result_q[AW-1:8]; // [RULE5]
			`ACGR_SFR_RESULT_LOW:   sfr_rdata <= result_q[7:0];
			default:                sfr_rdata <= 8'h00;
			endcase
		end
	end
endmodule // acgr_top

// File: tb/acgr_top_monitor.sv
// acgr_top_monitor.sv: port checks for the gain and config registers.
// assumes: bound into acgr_top; one clock, async active-low reset.
module acgr_top_monitor (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic [7:0]  sfr_addr,
	input wire logic        sfr_wr,
	input wire logic [7:0]  sfr_wdata,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_rdata,
	input wire logic [11:0] gain_word,
	input wire logic        extra_gain_flag,
	input wire logic [17:0] gain_scaled,
	input wire logic [4:0]  input_select_field,
	input wire logic [1:0]  input_route,
	input wire logic [3:0]  input_pin,
	input wire logic        gain_write_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	AST_GAIN_SCALED: assert property (
		gain_scaled == {6'h00, gain_word} +
		(extra_gain_flag ? 18'h00040 : 18'h00000))
		else $error("scaled gain wrong");
	AST_ROUTE_PIN: assert property (
		!input_select_field[4] |->
		input_route == 2'h0 && input_pin == input_select_field[3:0])
		else $error("pin route wrong");
	AST_ROUTE_TEMP: assert property (
		input_select_field == 5'h18 |-> input_route == 2'h1)
		else $error("temp route wrong");
	AST_ROUTE_SUPPLY: assert property (
		input_select_field == 5'h19 |-> input_route == 2'h2)
		else $error("supply route wrong");
	AST_ROUTE_GND: assert property (
		input_select_field >= 5'h1a |-> input_route == 2'h3)
		else $error("ground route wrong");
	AST_SEL_WRITE: assert property (
		sfr_wr && sfr_addr == 8'hbb |=>
		input_select_field == $past(sfr_wdata[4:0]))
		else $error("select write lost");
	AST_WE_WRITE: assert property (
		sfr_wr && sfr_addr == 8'hbc |=>
		gain_write_enable == $past(sfr_wdata[0]))
		else $error("write enable lost");
	AST_GAIN_LOCK: assert property (
		sfr_wr && sfr_addr == 8'hbd && !gain_write_enable |=>
		$stable(gain_word))
		else $error("gain changed while locked");
	AST_SEL_READ: assert property (
		sfr_rd && !sfr_wr && sfr_addr == 8'hbb |=>
		sfr_rdata[4:0] == $past(input_select_field))
		else $error("select readback wrong");
endmodule // acgr_top_monitor

bind acgr_top acgr_top_monitor u_acgr_top_monitor (
	.clock(clock), .rst_n(rst_n),
	.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
	.sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .gain_word(gain_word),
	.extra_gain_flag(extra_gain_flag), .gain_scaled(gain_scaled),
	.input_select_field(input_select_field), .input_route(input_route),
	.input_pin(input_pin), .gain_write_enable(gain_write_enable));

// File: tb/acgr_top_tb.sv
// acgr_top_tb.sv: self-checking bench for the gain and config block.
// assumes: design files compiled first; monitor bound separately.
module acgr_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0;
	logic        burst_enable = 0, burst_osc_tick = 0, conv_clear = 0;
	logic        sample_valid = 0;
	logic [7:0]  sfr_addr = 0, sfr_wdata = 0;
	logic [11:0] sample = 0;
	logic [1:0]  bcnt_q = 0;
	wire  [7:0]  sfr_rdata;
	wire         sar_tick, extra_gain_flag, result_valid, gain_write_enable;
	wire  [11:0] gain_word;
	wire  [17:0] gain_scaled;
	wire  [4:0]  input_select_field;
	wire  [1:0]  input_route;
	wire  [3:0]  input_pin;
	wire  [15:0] result;
	int          n_fail = 0, n_compared = 0;
	acgr_top u_acgr_top (.clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
		.sfr_rdata(sfr_rdata), .burst_enable(burst_enable),
		.burst_osc_tick(burst_osc_tick), .conv_clear(conv_clear),
		.sample_valid(sample_valid), .sample(sample), .sar_tick(sar_tick),
		.gain_word(gain_word), .extra_gain_flag(extra_gain_flag),
		.gain_scaled(gain_scaled), .input_select_field(input_select_field),
		.input_route(input_route), .input_pin(input_pin), .result(result),
		.result_valid(result_valid), .gain_write_enable(gain_write_enable));
	// ----------------------------------------------------------------
	// clock, burst source ticks every third clock
	// ----------------------------------------------------------------
	initial forever #25 clock = ~clock;
	always @(posedge clock) begin
		#5;
		burst_osc_tick = (bcnt_q == 2'h2);
		bcnt_q = (bcnt_q == 2'h2) ? 2'h0 : bcnt_q + 2'h1;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task step; @(posedge clock); #5; endtask
	task test_done;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task tmo; n_fail++; $display("mismatch wait exp 1 seen 0"); test_done; endtask
	task chk(input string nm, input logic [17:0] s, input logic [17:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a; sfr_wdata = d; sfr_wr = 1; step; sfr_wr = 0; step;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		sfr_addr = a; sfr_rd = 1; step; sfr_rd = 0; d = sfr_rdata; step;
	endtask
	task gw(input logic [7:0] a, input logic [7:0] d);
		wr(8'hbe, a); wr(8'hbd, d);
	endtask
	task wait_tick(output int n);
		n = 0;
		do begin step; n++; if (n > 300) tmo; end while (sar_tick !== 1'b1);
	endtask
	function int nsum(input logic [1:0] r);
		return (r == 2'h0) ? 1 : (r == 2'h1) ? 4 : (r == 2'h2) ? 8 : 16;
	endfunction
	function logic [1:0] xroute(input logic [4:0] c);
		return !c[4] ? 2'h0 : (c == 5'h18) ? 2'h1 : (c == 5'h19) ? 2'h2 : 2'h3;
	endfunction
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] v; logic [11:0] g; logic f; logic [4:0] c; logic [15:0] s;
		logic [4:0] cs [6]; int n;
		cs = '{5'h00, 5'h0f, 5'h18, 5'h19, 5'h1a, 5'h1f};
		void'($urandom(97779));
		repeat (4) @(posedge clock);
		#5 rst_n = 1; step;
		chk("gain_word", gain_word, 12'hfc0);
		chk("extra_gain_flag", extra_gain_flag, 1'b1);
		chk("gain_scaled", gain_scaled, 18'h01000);
		chk("input_route", input_route, 2'h3);
		rd(8'hbb, v); chk("input_select", v, 8'h1f);
		rd(8'hbc, v); chk("converter_config", v, 8'hf8);
		rd(8'h10, v); chk("unmapped", v, 8'h00);
		gw(8'h04, 8'h12); chk("gain_locked", gain_word, 12'hfc0);
		wr(8'hbc, 8'hf9); chk("gain_write_enable", gain_write_enable, 1'b1);
		gw(8'h05, 8'hff); chk("gain_bad_addr", gain_word, 12'hfc0);
		for (int i = 0; i < 6; i++) begin
			g = (i == 0) ? 12'hfff : 12'($urandom);
			f = (i == 0) ? 1'b1 : 1'($urandom);
			gw(8'h04, g[11:4]); gw(8'h07, {g[3:0], 4'h0}); gw(8'h08, {7'h00, f});
			chk("gain_word", gain_word, g);
			chk("extra_gain_flag", extra_gain_flag, f);
			chk("gain_scaled", gain_scaled, {6'h00, g} + (f ? 18'd64 : 18'd0));
		end
		wr(8'hbc, 8'hf8); // gain writes closed before converting
		for (int i = 0; i < 8; i++) begin
			c = (i < 6) ? cs[i] : {1'b0, 4'($urandom)};
			wr(8'hbb, {3'($urandom), c});
			chk("input_route", input_route, xroute(c));
			if (!c[4]) chk("input_pin", input_pin, c[3:0]);
			rd(8'hbb, v); chk("input_select", v[4:0], c);
			chk("select_unused", v[7:5], 3'h0);
		end
		for (int i = 0; i < 4; i++) begin
			c = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom % 8);
			burst_enable = (i >= 2);
			wr(8'hbc, {c, 3'h0});
			wait_tick(n); wait_tick(n); wait_tick(n);
			chk("sar_period", n, (c + 1) * (burst_enable ? 3 : 1));
		end
		burst_enable = 0;
		for (int r = 0; r < 4; r++) begin
			wr(8'hbc, {5'h00, 2'(r), 1'b0});
			conv_clear = 1; step; conv_clear = 0;
			s = 0;
			repeat (nsum(2'(r))) begin
				sample = (r == 3) ? 12'hfff : 12'($urandom);
				s += sample; sample_valid = 1; step;
			end
			sample_valid = 0; n = 0;
			while (result_valid !== 1'b1) begin step; n++; if (n > 8) tmo; end
			chk("result", result, s);
			rd(8'hbe, v);
			chk("result_high", v, s[15:8]);
			rd(8'hbd, v);
			chk("result_low", v, s[7:0]);
		end
		test_done;
	end
endmodule // acgr_top_tb
